// ==== rtl/serial_eeprom_command_port.sv ====
// Function
// - port register bits 3..0 always read back zero.
// - select bit 4, clock bit 5, data in bit 6, data out bit 7.
// - read data shifts onto data out at each serial clock rising edge.
// - data out floats except while a read or status poll drives it.
// - data in is sampled at the serial clock rising edge.
// - port register sits at pointer 40h of bank 1, indirect access only.
// - address sent msb first; 7 bits, or 9 with a leading dummy.
// - opcode 10 read, 11 erase byte, 01 write byte.
// - opcode 00: first address bits 11 enable, 00 disable, 10 erase all, 01 write all.
// - write or erase runs a timed cycle; instructions ignored meanwhile.
// - read emits one dummy zero, then the byte msb first.
// - read auto-increments address, next byte follows without dummy.
// - read works whether writes are enabled or not.
// - byte write data follows address msb first; cycle starts at select low.
// - byte write erases the location first, then programs it.
// - with select high, data out low while busy, high when done.
// - write enable holds until disable instruction or power loss.
// - writes and erases refused while disabled.
// - erase all sets every bit to one.
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_command_port
   import eeprom_pkg::*;
#(
   parameter int ADDR_W         = 7,
   parameter int WRITE_CYCLE_NS = eeprom_pkg::WRITE_CYCLE_NS
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // indirect data memory access
   input  wire logic        acc_indirect,
   input  wire logic        acc_bank,
   input  wire logic [7:0]  acc_ptr,
   input  wire logic        acc_wr,
   input  wire logic        acc_rd,
   input  wire logic [7:0]  acc_wdata,
   output logic      [7:0]  acc_rdata,
   // serial data out as a three-state bit
   output logic             ser_out,
   output logic             ser_out_oe
);

   localparam int DEPTH       = 2 ** ADDR_W;
   localparam int ADDR_LEN    = (ADDR_W > 7) ? ADDR_W + 1 : ADDR_W;
   // least time, so round up
   localparam int WRITE_CYCLES = (WRITE_CYCLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W       = $clog2(WRITE_CYCLES + 1);
   logic              sel;
   logic              sclk;
   logic              sin;
   logic              sclk_q;
   logic              sel_q;
   state_t            state;
   pend_t             pend;
   logic [3:0]        cnt;
   logic [1:0]        op;
   logic [8:0]        sh;
   logic [ADDR_W-1:0] addr;
   logic [7:0]        data;
   logic [7:0]        rbuf;
   logic              wr_enable;
   logic              show_status;
   logic [CNT_W-1:0]  busy_cnt;
   logic [7:0]        mem [DEPTH];
   logic              hit;
   logic              sk_rise;
   logic              sel_fall;
   logic [8:0]        next_sh;
   logic [1:0]        sub;
   logic              last_addr;
   logic              start_wr;
   logic              busy_done;
   logic [ADDR_W-1:0] addr_inc;
   logic [7:0]        port_val;
   assign hit       = acc_indirect && (acc_bank == PORT_BANK) && (acc_ptr == PORT_PTR);
   assign sk_rise   = sclk && !sclk_q;
   assign sel_fall  = sel_q && !sel;
   assign next_sh   = {sh[7:0], sin};
   assign sub       = next_sh[ADDR_LEN-1 -: 2];
   assign last_addr = sel && (state == st_addr) && sk_rise && (cnt == 4'(ADDR_LEN - 1));
   assign start_wr  = sel_fall && (pend != pend_none) && wr_enable && (state != st_busy);
   assign busy_done = (state == st_busy) && (busy_cnt == '0);
   assign addr_inc  = addr + 1'b1;
   always_comb begin
      port_val          = PORT_RESET;
      port_val[SEL_BIT] = sel;
      port_val[CLK_BIT] = sclk;
      port_val[IN_BIT]  = sin;
      // a floating bit reads as zero
      port_val[OUT_BIT] = ser_out_oe && ser_out;
   end

   ////////////////////////////////////////////////////////////////////////////
   // port register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sel       <= PORT_RESET[SEL_BIT];
         sclk      <= PORT_RESET[CLK_BIT];
         sin       <= PORT_RESET[IN_BIT];
         sclk_q    <= 1'b0;
         sel_q     <= 1'b0;
         acc_rdata <= 8'h00;
      end else begin
         sclk_q <= sclk;
         sel_q  <= sel;
         if (hit && acc_wr) begin
            sel  <= acc_wdata[SEL_BIT];
            sclk <= acc_wdata[CLK_BIT];
            sin  <= acc_wdata[IN_BIT];
         end
         acc_rdata <= (hit && acc_rd) ? port_val : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // instruction decoder
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= st_idle;
         pend  <= pend_none;
         cnt   <= 4'h0;
         op    <= 2'h0;
         sh    <= 9'h000;
         addr  <= '0;
         data  <= 8'h00;
         rbuf  <= 8'h00;
      end else if (state == st_busy) begin
         // clock edges meanwhile are dropped
         if (busy_done) begin
            state <= st_idle;
            pend  <= pend_none;
         end
      end else if (!sel) begin
         // select low ends the frame and maybe starts the cycle
         state <= start_wr ? st_busy : st_idle;
         if (!start_wr) begin
            pend <= pend_none;
         end
         cnt <= 4'h0;
      end else if (sk_rise) begin
         unique case (state)
            st_idle: begin
               if (sin == START_VAL) begin
                  state <= st_op;
                  cnt   <= 4'h0;
               end
            end
            st_op: begin
               op  <= {op[0], sin};
               cnt <= cnt + 4'h1;
               if (cnt == 4'h1) begin
                  state <= st_addr;
                  cnt   <= 4'h0;
               end
            end
            st_addr: begin
               sh  <= next_sh;
               cnt <= cnt + 4'h1;
               if (last_addr) begin
                  cnt  <= 4'h0;
                  addr <= next_sh[ADDR_W-1:0];
                  unique case (op)
                     OP_READ: begin
                        state <= st_rdout;
                        rbuf  <= mem[next_sh[ADDR_W-1:0]];
                     end
                     OP_ERASE: begin
                        state <= st_hold;
                        pend  <= pend_erase;
                     end
                     OP_WRITE: state <= st_wdata;
                     OP_EXT: begin
                        unique case (sub)
                           SUB_ERASE_ALL: begin
                              state <= st_hold;
                              pend  <= pend_erase_all_cmd;
                           end
                           SUB_WRITE_ALL: state <= st_wdata;
                           SUB_ENABLE,
                           SUB_DISABLE:   state <= st_hold;
                        endcase
                     end
                  endcase
               end
            end
            st_wdata: begin
               sh  <= next_sh;
               cnt <= cnt + 4'h1;
               if (cnt == 4'h7) begin
                  data  <= next_sh[7:0];
                  pend  <= (op == OP_WRITE) ? pend_write : pend_write_all_cmd;
                  state <= st_hold;
               end
            end
            st_rdout: begin
               rbuf <= {rbuf[6:0], DUMMY_VAL};
               cnt  <= cnt + 4'h1;
               if (cnt == 4'h7) begin
                  addr <= addr_inc;
                  rbuf <= mem[addr_inc];
                  cnt  <= 4'h0;
               end
            end
            st_hold, st_busy: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write enable latch, power-on disabled
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_enable <= 1'b0;
      end else if (last_addr && op == OP_EXT) begin
         if (sub == SUB_ENABLE) begin
            wr_enable <= 1'b1;
         end else if (sub == SUB_DISABLE) begin
            wr_enable <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // self-timed write cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         busy_cnt <= '0;
      end else if (start_wr) begin
         busy_cnt <= CNT_W'(WRITE_CYCLES - 1);
      end else if (state == st_busy && busy_cnt != '0) begin
         busy_cnt <= busy_cnt - 1'b1;
      end
   end
   // status stays visible until a new start bit or select drops after the cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         show_status <= 1'b0;
      end else if (start_wr) begin
         show_status <= 1'b1;
      end else if (state == st_idle && (!sel || (sk_rise && sin == START_VAL))) begin
         show_status <= 1'b0;
      end
   end
   // array is nonvolatile, so it has no reset; whole-array ops take one edge
   always_ff @(posedge clk_sys) begin
      if (start_wr) begin
         unique case (pend)
            pend_write,
            pend_erase: mem[addr] <= ERASED_BYTE;
            pend_erase_all_cmd,
            pend_write_all_cmd: begin
               for (int i = 0; i < DEPTH; i++) begin
                  mem[i] <= ERASED_BYTE;
               end
            end
            default: ;
         endcase
      end else if (busy_done) begin
         if (pend == pend_write) begin
            mem[addr] <= data;
         end else if (pend == pend_write_all_cmd) begin
            for (int i = 0; i < DEPTH; i++) begin
               mem[i] <= data;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial data out
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ser_out    <= 1'b0;
         ser_out_oe <= 1'b0;
      end else if (!sel) begin
         ser_out    <= 1'b0;
         ser_out_oe <= 1'b0;
      end else if (show_status && (state == st_busy || state == st_idle)) begin
         ser_out    <= (state != st_busy);
         ser_out_oe <= 1'b1;
      end else if (last_addr && op == OP_READ) begin
         ser_out    <= DUMMY_VAL;
         ser_out_oe <= 1'b1;
      end else if (state == st_rdout) begin
         ser_out_oe <= 1'b1;
         if (sk_rise) begin
            ser_out <= rbuf[7];
         end
      end else begin
         ser_out    <= 1'b0;
         ser_out_oe <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   property p_low_zero;
      acc_rd |=> acc_rdata[3:0] == 4'h0;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("low port bits not zero");
   property p_bit_map;
      (hit && acc_wr) |=> sel == $past(acc_wdata[4]) && sclk == $past(acc_wdata[5])
                          && sin == $past(acc_wdata[6]);
   endproperty
   a_bit_map: assert property (p_bit_map) else $error("port bit mapping wrong");
   property p_miss;
      (acc_wr && !hit) |=> sel == $past(sel) && sclk == $past(sclk);
   endproperty
   a_miss: assert property (p_miss) else $error("write off the port changed it");
   property p_shift_out;
      (state == st_rdout && sel && sk_rise) |=> ser_out == $past(rbuf[7]);
   endproperty
   a_shift_out: assert property (p_shift_out) else $error("read bit not shifted");
   property p_float;
      ser_out_oe |-> $past(sel) && ($past(state) == st_rdout || $past(last_addr)
                     || $past(show_status));
   endproperty
   a_float: assert property (p_float) else $error("data out driven outside read");
   property p_dummy;
      (last_addr && op == OP_READ && sel) |=> ser_out_oe && ser_out == 1'b0 ##1
         state == st_rdout;
   endproperty
   a_dummy: assert property (p_dummy) else $error("no dummy zero before data");
   property p_start;
      start_wr |=> state == st_busy && busy_cnt == CNT_W'(WRITE_CYCLES - 1);
   endproperty
   a_start: assert property (p_start) else $error("write cycle not started");
   property p_refuse;
      (sel_fall && !wr_enable && state != st_busy) |=> state == st_idle;
   endproperty
   a_refuse: assert property (p_refuse) else $error("write ran while disabled");
   property p_busy_quiet;
      (state == st_busy && !busy_done) |=> wr_enable == $past(wr_enable) && state == st_busy;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("busy cycle disturbed");
   property p_poll;
      (state == st_busy && sel && show_status) |=> ser_out_oe && !ser_out;
   endproperty
   a_poll: assert property (p_poll) else $error("busy not shown low");
   property p_enable_hold;
      (wr_enable && !(last_addr && op == OP_EXT && sub == SUB_DISABLE)) |=> wr_enable;
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("enable lost");
   property p_wrap;
      (state == st_rdout && sel && sk_rise && cnt == 4'h7) |=> addr == $past(addr_inc)
                                                              && cnt == 4'h0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("read address not advanced");
   c_read:  cover property (last_addr && op == OP_READ);
   c_write: cover property (start_wr && pend == pend_write);
   c_erase_all_cmd:  cover property (start_wr && pend == pend_erase_all_cmd);
   c_ready: cover property (state == st_idle && show_status && ser_out_oe && ser_out);

endmodule

`default_nettype wire

// ==== rtl/eeprom_pkg.sv ====
package eeprom_pkg;

   // port register location, reached only through the indirect pointer
   localparam logic       PORT_BANK      = 1'b1;
   localparam logic [7:0] PORT_PTR       = 8'h40;
   localparam logic [7:0] PORT_RESET     = 8'h00;

   // bit positions in the port register
   localparam int         SEL_BIT        = 4;
   localparam int         CLK_BIT        = 5;
   localparam int         IN_BIT         = 6;
   localparam int         OUT_BIT        = 7;

   // serial framing
   localparam logic       START_VAL      = 1'b1;
   localparam logic       DUMMY_VAL      = 1'b0;
   localparam logic [7:0] ERASED_BYTE    = 8'hff;

   // opcodes and the sub-functions of opcode 00
   localparam logic [1:0] OP_EXT         = 2'h0;
   localparam logic [1:0] OP_WRITE       = 2'h1;
   localparam logic [1:0] OP_READ        = 2'h2;
   localparam logic [1:0] OP_ERASE       = 2'h3;
   localparam logic [1:0] SUB_DISABLE    = 2'h0;
   localparam logic [1:0] SUB_WRITE_ALL  = 2'h1;
   localparam logic [1:0] SUB_ERASE_ALL  = 2'h2;
   localparam logic [1:0] SUB_ENABLE     = 2'h3;

   // timing
   localparam int         CLK_MHZ        = 125;
   localparam int         WRITE_CYCLE_NS = 2000000;

   typedef enum logic [2:0] {
      st_idle, st_op, st_addr, st_wdata, st_rdout, st_hold, st_busy
   } state_t;

   typedef enum logic [2:0] {
      pend_none, pend_write, pend_erase, pend_erase_all_cmd, pend_write_all_cmd
   } pend_t;

endpackage

// ==== tb/cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpu_model
   import eeprom_pkg::*;
(
   // clock
   input  wire logic       clk_sys,
   // indirect register access
   output logic            acc_indirect,
   output logic            acc_bank,
   output logic [7:0]      acc_ptr,
   output logic            acc_wr,
   output logic            acc_rd,
   output logic [7:0]      acc_wdata,
   input  wire logic [7:0] acc_rdata
);

   initial begin
      acc_indirect = 1'b0;
      acc_bank     = 1'b0;
      acc_ptr      = 8'h00;
      acc_wr       = 1'b0;
      acc_rd       = 1'b0;
      acc_wdata    = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one access, held until the edge that takes it; read data taken after it
   task automatic xfer(input logic ind, input logic bank, input logic [7:0] ptr,
                       input logic wr, input logic [7:0] d, output logic [7:0] r);
      @(posedge clk_sys);
      #1;
      acc_indirect = ind;
      acc_bank     = bank;
      acc_ptr      = ptr;
      acc_wr       = wr;
      acc_rd       = !wr;
      acc_wdata    = d;
      @(posedge clk_sys);
      #1;
      acc_wr       = 1'b0;
      acc_rd       = 1'b0;
      acc_indirect = 1'b0;
      acc_wdata    = ~d;
      r            = acc_rdata;
   endtask

   task automatic put(input logic [7:0] d);
      logic [7:0] r;
      xfer(1'b1, PORT_BANK, PORT_PTR, 1'b1, d, r);
   endtask

   task automatic get(output logic [7:0] r);
      xfer(1'b1, PORT_BANK, PORT_PTR, 1'b0, 8'h00, r);
   endtask

   // data in settles with clock low, then clock rises; data out read back later
   task automatic sbit(input logic b, output logic o);
      logic [7:0] r;
      put({1'b0, b, 1'b0, 1'b1, 4'h0});
      put({1'b0, b, 1'b1, 1'b1, 4'h0});
      repeat (2) @(posedge clk_sys);
      get(r);
      o = r[7];
   endtask

   // frame goes out msb first, start bit leading
   task automatic send(input logic [31:0] v, input int n);
      logic o;
      for (int i = n - 1; i >= 0; i--) begin
         sbit(v[i], o);
      end
   endtask

endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import eeprom_pkg::*;

   logic       clk_sys;
   logic       arst_n;
   logic       acc_indirect;
   logic       acc_bank;
   logic [7:0] acc_ptr;
   logic       acc_wr;
   logic       acc_rd;
   logic [7:0] acc_wdata;
   logic [7:0] acc_rdata;
   logic       ser_out;
   logic       ser_out_oe;
   int         n_fail = 0;
   int         tests_run = 0;

   // ctrl byte: bit1 indirect, bit0 bank; then pointer, write data, read back
   localparam logic [7:0] ROWS [7][4] = '{
      '{8'h03, 8'h40, 8'h50, 8'h50}, '{8'h03, 8'h40, 8'h8f, 8'h00},
      '{8'h02, 8'h40, 8'h50, 8'h00}, '{8'h01, 8'h40, 8'h50, 8'h00},
      '{8'h03, 8'h41, 8'h50, 8'h00}, '{8'h03, 8'h40, 8'h10, 8'h10},
      '{8'h03, 8'h40, 8'h00, 8'h00}};

   // short write cycle so a run stays small: 1000 clocks
   serial_eeprom_command_port #(.ADDR_W(7), .WRITE_CYCLE_NS(8000)) i_serial_eeprom_command_port (
      .clk_sys(clk_sys), .arst_n(arst_n), .acc_indirect(acc_indirect),
      .acc_bank(acc_bank), .acc_ptr(acc_ptr), .acc_wr(acc_wr), .acc_rd(acc_rd),
      .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .ser_out(ser_out),
      .ser_out_oe(ser_out_oe));

   cpu_model i_cpu_model (
      .clk_sys(clk_sys), .acc_indirect(acc_indirect), .acc_bank(acc_bank),
      .acc_ptr(acc_ptr), .acc_wr(acc_wr), .acc_rd(acc_rd),
      .acc_wdata(acc_wdata), .acc_rdata(acc_rdata));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic end_of_test;
      if (n_fail == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // select high again, data out low while busy, bounded wait for high
   task automatic poll;
      logic [7:0] r;
      i_cpu_model.put(8'h10);
      i_cpu_model.get(r);
      chk({7'h0, r[7]}, 8'h00);
      for (int k = 0; k < 800 && r[7] !== 1'b1; k++) begin
         i_cpu_model.get(r);
      end
      chk({7'h0, r[7]}, 8'h01);
      i_cpu_model.put(8'h00);
   endtask

   task automatic cmd(input logic [31:0] v, input int n, input logic busy);
      i_cpu_model.send(v, n);
      i_cpu_model.put(8'h00);
      if (busy) begin
         poll();
      end
   endtask

   task automatic rd(input logic [6:0] a, input int n, input logic [31:0] e);
      logic o;
      i_cpu_model.send({1'b1, OP_READ, a}, 10);
      chk({6'h0, ser_out_oe, ser_out}, 8'h02);
      for (int i = 8 * n - 1; i >= 0; i--) begin
         i_cpu_model.sbit(1'b0, o);
         chk({7'h0, o}, {7'h0, e[i]});
      end
      i_cpu_model.put(8'h00);
      repeat (3) @(posedge clk_sys);
      chk({7'h0, ser_out_oe}, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // longest path is eight write cycles plus framing, well under this
   initial begin
      #400000;
      n_fail++;
      end_of_test();
   end

   initial begin
      logic [7:0] r;
      arst_n = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      for (int i = 0; i < 7; i++) begin
         i_cpu_model.xfer(ROWS[i][0][1], ROWS[i][0][0], ROWS[i][1], 1'b1, ROWS[i][2], r);
         i_cpu_model.get(r);
         chk(r, ROWS[i][3]);
      end
      i_cpu_model.put(8'h50);
      i_cpu_model.xfer(1'b1, 1'b1, 8'h41, 1'b0, 8'h00, r);
      chk(r, 8'h00);
      i_cpu_model.put(8'h00);
      chk({7'h0, ser_out_oe}, 8'h00);
      cmd({1'b1, OP_EXT, SUB_ENABLE, 5'h00}, 10, 1'b0);
      cmd({1'b1, OP_WRITE, 7'h7f, 8'h55}, 18, 1'b1);
      cmd({1'b1, OP_EXT, SUB_ERASE_ALL, 5'h00}, 10, 1'b1);
      cmd({1'b1, OP_WRITE, 7'h10, 8'ha5}, 18, 1'b1);
      cmd({1'b1, OP_WRITE, 7'h11, 8'h5a}, 18, 1'b1);
      cmd({1'b1, OP_EXT, SUB_DISABLE, 5'h00}, 10, 1'b0);
      rd(7'h0f, 4, 32'hffa55aff);
      cmd({1'b1, OP_WRITE, 7'h12, 8'h00}, 18, 1'b0);
      cmd({1'b1, OP_ERASE, 7'h10}, 10, 1'b0);
      rd(7'h10, 3, 32'h00a55aff);
      cmd({1'b1, OP_EXT, SUB_ENABLE, 5'h00}, 10, 1'b0);
      cmd({1'b1, OP_ERASE, 7'h11}, 10, 1'b1);
      rd(7'h11, 1, 32'h000000ff);
      cmd({1'b1, OP_EXT, SUB_WRITE_ALL, 5'h00, 8'h3c}, 18, 1'b0);
      // disable sent mid-cycle must be dropped, so the next write still lands
      cmd({1'b1, OP_EXT, SUB_DISABLE, 5'h00}, 10, 1'b1);
      cmd({1'b1, OP_WRITE, 7'h00, 8'h11}, 18, 1'b1);
      rd(7'h00, 2, 32'h0000113c);
      // power loss mid-run: port bits clear, the array keeps its bytes
      @(posedge clk_sys);
      #1;
      arst_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      i_cpu_model.get(r);
      chk(r, 8'h00);
      chk({7'h0, ser_out_oe}, 8'h00);
      cmd({1'b1, OP_EXT, SUB_ENABLE, 5'h00}, 10, 1'b0);
      cmd({1'b1, OP_WRITE, 7'h7f, 8'h55}, 18, 1'b1);
      cmd({1'b1, OP_EXT, SUB_DISABLE, 5'h00}, 10, 1'b0);
      cmd({1'b1, OP_WRITE, 7'h7e, 8'h77}, 18, 1'b0);
      rd(7'h7e, 2, 32'h00003c55);
      end_of_test();
   end

endmodule

`default_nettype wire
